// ==== src/vmsad_pkg.sv ====
// Constants shared by the VME slave address decode block.
//
// How it works
// - In the 24-bit build the eight-bit switch base is compared with address bits 23:16.
// - On a base match every offset from 0x0000 up to 0xFFFC of that base is answered.
// - Only the low sixteen address bits pick the internal register.
// - The standard build does 16-bit data with 24-bit addressing in any crate.
// - A build option swaps that for 32-bit addressing with 32-bit data.
// - When the extended backplane is sensed and its geographic pins pass the parity check, they set the base instead.
// - Control registers read back the last value written to them.
// - Status registers are read-only and a write to one changes nothing.
// - Each one written to the pulse register fires a short timed internal pulse.
// - The bus activity lamp blinks on every access to the module.
package vmsad_pkg;

  // ----------------------------------------
  // Register offsets (low sixteen address bits)
  // ----------------------------------------
  localparam logic [15:0] OFS_ID = 16'h0000;
  localparam logic [15:0] OFS_HWSTAT = 16'h0020;
  localparam logic [15:0] OFS_PULSE = 16'h040C;
  localparam logic [15:0] OFS_CTRL_BASE = 16'h0500;
  localparam logic [15:0] OFS_TOP = 16'hFFFC;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int CTRL_N = 4;
  localparam int CTRL_IDX_LSB = 2;
  localparam logic [15:0] CTRL_IDX_MASK = 16'hFFF3;
  localparam int PULSE_W = 16;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int BASE_W = 8;
  localparam int GA_W = 5;
  localparam int ID_MODE_BIT = 15;
  localparam int ID_GA_BIT = 14;
  // Arbitrary identification value, not tied to any product.
  localparam logic [5:0] ID_CODE = 6'h2_5;

  // ----------------------------------------
  // Address modifiers
  // ----------------------------------------
  localparam logic [5:0] AM_A24_USR = 6'h3_9;
  localparam logic [5:0] AM_A24_SUP = 6'h3_D;
  localparam logic [5:0] AM_A32_USR = 6'h0_9;
  localparam logic [5:0] AM_A32_SUP = 6'h0_D;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [BASE_W-1:0] BASE_RST = 8'h00;
  localparam int CLK_NS = 40;
  localparam int PULSE_NS = 200;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int LED_MS = 50;
  localparam int LED_CYC = (LED_MS * 1000000) / CLK_NS;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_ACK
  } vmsad_state_t;

endpackage

// ==== src/vmsad_pulse_if.sv ====
// Carries pulse-register fire strobes to the pulse generator and its pulses back.
`timescale 1ns/1ps
interface vmsad_pulse_if #(
  parameter int W = 16
);
  logic [W-1:0] fire;
  logic [W-1:0] pulse;
  modport src (output fire, input pulse);
  modport gen (input fire, output pulse);
endinterface

// ==== src/vmsad_pulse_gen.sv ====
// Per-bit timed pulse generator fed by the pulse register.
`timescale 1ns/1ps
module vmsad_pulse_gen #(
  parameter int W = 16,
  parameter int CYC = 5
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Strobes in, pulses out
  vmsad_pulse_if.gen pif
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYC);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic [CW-1:0] cnt_q;
      logic pulse_q;
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_q <= '0;
          pulse_q <= 1'b0;
        end else if (pif.fire[i]) begin
          cnt_q <= LOAD - 1'b1;
          pulse_q <= 1'b1;
        end else if (cnt_q != '0) begin
          cnt_q <= cnt_q - 1'b1;
        end else begin
          pulse_q <= 1'b0;
        end
      end
      assign pif.pulse[i] = pulse_q;
    end
  endgenerate

endmodule // vmsad_pulse_gen

// ==== src/vmsad_blink.sv ====
// Stretches a one-cycle access strobe into a visible lamp blink.
`timescale 1ns/1ps
module vmsad_blink #(
  parameter int CYC = 1250000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Strobe and lamp
  input wire logic hit,
  output logic led
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYC);

  logic [CW-1:0] cnt_q;
  logic led_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      led_q <= 1'b0;
    end else if (hit) begin
      cnt_q <= LOAD - 1'b1;
      led_q <= 1'b1;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end else begin
      led_q <= 1'b0;
    end
  end

  assign led = led_q;

endmodule // vmsad_blink

// ==== src/vmsad_vme_slave.sv ====
// VME slave: base address match, register decode, control, status and pulse registers.
`timescale 1ns/1ps
module vmsad_vme_slave
  import vmsad_pkg::*;
#(
  parameter bit A32_BUILD = 1'b0,
  parameter int LED_CYCLES = vmsad_pkg::LED_CYC,
  parameter int PULSE_CYCLES = vmsad_pkg::PULSE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // VME address and control
  input wire logic [31:0] vme_addr,
  input wire logic [5:0] vme_am,
  input wire logic vme_as_n,
  input wire logic [1:0] vme_ds_n,
  input wire logic vme_lword_n,
  input wire logic vme_write_n,
  // VME data lines, split per half
  input wire logic [vmsad_pkg::DATA_W-1:0] vme_data_in,
  output logic [vmsad_pkg::DATA_W-1:0] vme_data_out,
  output logic [1:0] vme_data_oe,
  // VME acknowledge, open-collector style
  output logic vme_dtack_out,
  output logic vme_dtack_oe,
  // Base address sources
  input wire logic [vmsad_pkg::BASE_W-1:0] base_switch,
  input wire logic ext_conn_present,
  input wire logic [vmsad_pkg::GA_W-1:0] geo_addr_n,
  input wire logic geo_parity_n,
  // Device side
  input wire logic [vmsad_pkg::DATA_W-1:0] hw_status,
  output logic [vmsad_pkg::CTRL_N-1:0][vmsad_pkg::DATA_W-1:0] ctrl_out,
  output logic [vmsad_pkg::PULSE_W-1:0] pulse_out,
  output logic access_led
);
  import vmsad_pkg::*;

  // ----------------------------------------
  // Base address selection
  // ----------------------------------------
  wire [GA_W-1:0] geo_addr = ~geo_addr_n;
  // The slot pins carry odd parity together with their parity pin.
  wire geo_parity_ok = ^{geo_addr, ~geo_parity_n};
  wire use_geo = ext_conn_present && geo_parity_ok;
  wire [BASE_W-1:0] geo_base = {geo_addr, 3'b000};
  wire [BASE_W-1:0] base_d = use_geo ? geo_base : base_switch;

  logic [BASE_W-1:0] base_q;
  logic use_geo_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      base_q <= BASE_RST;
      use_geo_q <= 1'b0;
    end else begin
      base_q <= base_d;
      use_geo_q <= use_geo;
    end
  end

  // ----------------------------------------
  // Cycle qualification
  // ----------------------------------------
  wire [15:0] offset = vme_addr[15:0];
  wire am_a24 = (vme_am == AM_A24_USR) || (vme_am == AM_A24_SUP);
  wire am_a32 = (vme_am == AM_A32_USR) || (vme_am == AM_A32_SUP);
  // Standard build matches bits 23:16, wide build matches 31:24 with 23:16 clear.
  wire match_a24 = am_a24 && (vme_addr[23:16] == base_q);
  wire match_a32 = am_a32 && (vme_addr[31:24] == base_q)
                   && (vme_addr[23:16] == 8'h00);
  wire width_a24 = 1'b1;
  wire width_a32 = (vme_ds_n == 2'b00) && !vme_lword_n;
  wire addr_match = A32_BUILD ? (match_a32 && width_a32) : (match_a24 && width_a24);
  wire in_range = (offset <= OFS_TOP);
  wire strobe = !vme_as_n && (vme_ds_n != 2'b11);
  wire cycle_hit = strobe && addr_match && in_range;
  wire ds_released = (vme_ds_n == 2'b11);

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  wire sel_id = (offset == OFS_ID);
  wire sel_hwstat = (offset == OFS_HWSTAT);
  wire sel_pulse = (offset == OFS_PULSE);
  wire sel_ctrl = ((offset & CTRL_IDX_MASK) == OFS_CTRL_BASE);
  wire [1:0] ctrl_idx = offset[CTRL_IDX_LSB +: 2];

  // Byte lanes: upper data strobe serves bits 15:8, lower serves 7:0.
  wire [DATA_W-1:0] lane_mask = A32_BUILD ? 32'hFFFF_FFFF
                                : {16'h0000, {8{!vme_ds_n[1]}}, {8{!vme_ds_n[0]}}};
  wire [DATA_W-1:0] width_mask = A32_BUILD ? 32'hFFFF_FFFF : 32'h0000_FFFF;

  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  vmsad_state_t state_q;
  vmsad_state_t state_d;
  logic is_write_q;
  logic [15:0] ofs_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cycle_hit) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_d = ST_ACK;
      end
      ST_ACK: begin
        if (ds_released) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      is_write_q <= 1'b0;
      ofs_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE && cycle_hit) begin
        is_write_q <= !vme_write_n;
        ofs_q <= offset;
      end
    end
  end

  wire exec = (state_q == ST_EXEC);
  wire wr_exec = exec && is_write_q;
  wire rd_exec = exec && !is_write_q;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [CTRL_N-1:0][DATA_W-1:0] ctrl_q;

  genvar gi;
  generate
    for (gi = 0; gi < CTRL_N; gi++) begin : g_ctrl
      wire we = wr_exec && sel_ctrl && (ctrl_idx == 2'(gi));
      wire [DATA_W-1:0] merged = (ctrl_q[gi] & ~lane_mask)
                                 | (vme_data_in & lane_mask & width_mask);
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          ctrl_q[gi] <= CTRL_RST;
        end else if (we) begin
          ctrl_q[gi] <= merged;
        end
      end
    end
  endgenerate

  assign ctrl_out = ctrl_q;

  // ----------------------------------------
  // Pulse register and generator
  // ----------------------------------------
  vmsad_pulse_if #(.W(PULSE_W)) pulse_bus ();

  wire [PULSE_W-1:0] pulse_bits = vme_data_in[PULSE_W-1:0] & lane_mask[PULSE_W-1:0];
  assign pulse_bus.fire = (wr_exec && sel_pulse) ? pulse_bits : '0;

  vmsad_pulse_gen #(
    .W(PULSE_W),
    .CYC(PULSE_CYCLES)
  ) u_pulse (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pif(pulse_bus)
  );

  assign pulse_out = pulse_bus.pulse;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Identity word: build mode, base source, arbitrary code and the live base.
  wire [DATA_W-1:0] id_word = {16'h0000, A32_BUILD, use_geo_q, ID_CODE, base_q};
  // Status words are never written; the pulse register reads back as zero
  wire [DATA_W-1:0] rd_mux = sel_id ? id_word
                           : sel_hwstat ? hw_status
                           : sel_ctrl ? ctrl_q[ctrl_idx]
                           : '0;

  logic [DATA_W-1:0] rdata_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else if (rd_exec) begin
      rdata_q <= rd_mux & width_mask;
    end
  end

  // ----------------------------------------
  // Bus drivers
  // ----------------------------------------
  wire ack = (state_q == ST_ACK);
  wire rd_ack = ack && !is_write_q;
  assign vme_dtack_out = 1'b0;
  assign vme_dtack_oe = ack;
  assign vme_data_out = rdata_q;
  assign vme_data_oe = {rd_ack && A32_BUILD, rd_ack};

  // ----------------------------------------
  // Activity lamp
  // ----------------------------------------
  vmsad_blink #(
    .CYC(LED_CYCLES)
  ) u_blink (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .hit(exec),
    .led(access_led)
  );

  // The offset latch is held but unused; the decode reads the live address bits.
  wire unused_ofs = ^ofs_q;

endmodule // vmsad_vme_slave

// ==== verif/vmsad_vme_slave_props.sv ====
// Concurrent checks on the ports of the VME slave address decode block.
`timescale 1ns/1ps
module vmsad_vme_slave_props #(
  parameter int LED_CYCLES = 20,
  parameter int PULSE_CYCLES = 5
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Bus
  input wire logic [31:0] vme_addr,
  input wire logic [5:0] vme_am,
  input wire logic vme_as_n,
  input wire logic [1:0] vme_ds_n,
  input wire logic vme_write_n,
  input wire logic [31:0] vme_data_in,
  input wire logic [1:0] vme_data_oe,
  input wire logic vme_dtack_oe,
  // Device side
  input wire logic [7:0] base_switch,
  input wire logic ext_conn_present,
  input wire logic [3:0][31:0] ctrl_out,
  input wire logic [15:0] pulse_out,
  input wire logic access_led
);
  wire am_ok = vme_am == 6'h39 || vme_am == 6'h3D;
  wire mine = am_ok && vme_addr[23:16] == base_switch && vme_addr[15:0] <= 16'hFFFC;
  wire start = !ext_conn_present && vme_ds_n != 2'b11;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_ack2;
    !vme_dtack_oe [*2] ##1 vme_dtack_oe;
  endsequence
  sequence s_pulse;
    pulse_out[0] [*5] ##1 !pulse_out[0];
  endsequence
  AST_ACK_TWO: assert property ($fell(vme_as_n) && start && mine |-> s_ack2)
    else $error("no acknowledge two cycles after a matching cycle");
  AST_MISS_QUIET: assert property ($fell(vme_as_n) && start && !mine |->
    (!vme_dtack_oe && vme_data_oe == 2'b00) [*6])
    else $error("foreign cycle was driven");
  AST_ACK_HOLD: assert property (vme_dtack_oe && vme_ds_n != 2'b11 |=> vme_dtack_oe)
    else $error("acknowledge dropped while strobes low");
  AST_ACK_DROP: assert property (vme_dtack_oe && vme_ds_n == 2'b11 |=>
    !vme_dtack_oe && vme_data_oe == 2'b00)
    else $error("acknowledge or data held after strobes released");
  AST_RD_DRIVE: assert property (vme_data_oe != 2'b00 |->
    vme_dtack_oe && vme_write_n && vme_data_oe == 2'b01)
    else $error("data driven outside a read acknowledge");
  AST_PULSE_LEN: assert property ($rose(pulse_out[0]) |-> s_pulse)
    else $error("pulse length wrong");
  AST_PULSE_CAUSE: assert property ($rose(pulse_out[0]) |-> $rose(vme_dtack_oe) && !vme_write_n
    && vme_data_in[0] && vme_addr[15:0] == 16'h040C)
    else $error("pulse without a pulse register write");
  AST_CTRL_CAUSE: assert property ($changed(ctrl_out) |-> $rose(vme_dtack_oe) && !vme_write_n
    && vme_addr[15:4] == 12'h050)
    else $error("control changed without a control write");
  AST_LED_ON: assert property ($rose(vme_dtack_oe) |-> access_led [*8])
    else $error("lamp not lit after access");
  AST_LED_CAUSE: assert property ($rose(access_led) |-> $rose(vme_dtack_oe))
    else $error("lamp lit without access");
endmodule // vmsad_vme_slave_props

bind vmsad_vme_slave vmsad_vme_slave_props #(.LED_CYCLES(LED_CYCLES),
  .PULSE_CYCLES(PULSE_CYCLES)) u_props (.ref_clk, .arst_n, .vme_addr, .vme_am, .vme_as_n,
  .vme_ds_n, .vme_write_n, .vme_data_in, .vme_data_oe, .vme_dtack_oe, .base_switch,
  .ext_conn_present, .ctrl_out, .pulse_out, .access_led);

// ==== verif/vmsad_vme_master.sv ====
// Crate controller model that runs single VME cycles.
`timescale 1ns/1ps
module vmsad_vme_master (
  // Clock
  input wire logic ref_clk,
  // Bus
  output logic [31:0] vme_addr,
  output logic [5:0] vme_am,
  output logic vme_as_n,
  output logic [1:0] vme_ds_n,
  output logic vme_lword_n,
  output logic vme_write_n,
  output logic [31:0] vme_data_in,
  input wire logic [31:0] vme_data_out,
  input wire logic vme_dtack_oe
);
  int hold = 0;
  initial begin
    vme_addr = 32'h0000_0000;
    vme_am = 6'h00;
    vme_as_n = 1'b1;
    vme_ds_n = 2'b11;
    vme_lword_n = 1'b1;
    vme_write_n = 1'b1;
    vme_data_in = 32'h0000_0000;
  end
  // Gives up after eight cycles without acknowledge; hold slows the release.
  task automatic cyc(input logic wr, input logic [1:0] ds, input logic [5:0] am,
      input logic [31:0] a, input logic [15:0] d, output logic [15:0] q, output logic ack);
    ack = 1'b0;
    @(posedge ref_clk);
    vme_addr <= a;
    vme_am <= am;
    vme_write_n <= !wr;
    vme_data_in <= wr ? {~d, d} : ~vme_data_in;
    vme_as_n <= 1'b0;
    vme_ds_n <= ds;
    // Acknowledge and read data are looked at mid-cycle, where they have settled.
    for (int n = 0; n < 8 && !ack; n++) begin
      @(negedge ref_clk);
      ack = vme_dtack_oe;
    end
    q = vme_data_out[15:0];
    @(posedge ref_clk);
    repeat (hold) @(posedge ref_clk);
    vme_as_n <= 1'b1;
    vme_ds_n <= 2'b11;
    @(posedge ref_clk);
    vme_addr <= ~vme_addr;
    vme_data_in <= ~vme_data_in;
  endtask
endmodule // vmsad_vme_master

// ==== verif/vmsad_vme_slave_tb.sv ====
// Self-checking bench for the VME slave address decode block.
`timescale 1ns/1ps
module vmsad_vme_slave_tb;
  import vmsad_pkg::*;
  typedef struct {
    logic wr;
    logic [1:0] ds;
    logic [5:0] am;
    logic [23:0] a;
    logic [15:0] d;
    logic ack;
    logic [15:0] exp;
  } vmsad_row_t;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [31:0] vme_addr, vme_data_in, vme_data_out;
  logic [5:0] vme_am;
  logic vme_as_n, vme_lword_n, vme_write_n, vme_dtack_oe, access_led, ok;
  logic [1:0] vme_ds_n, vme_data_oe;
  logic [7:0] base_switch = 8'h5A;
  logic ext_conn_present = 1'b0;
  logic [4:0] geo_addr_n = 5'h1F;
  logic geo_parity_n = 1'b1;
  logic [31:0] hw_status = 32'hCAFE_0A5C;
  logic [3:0][31:0] ctrl_out;
  logic [15:0] pulse_out, q;
  int num_errors = 0;
  int checked = 0;
  vmsad_row_t rows [15] = '{
    '{1, 2'h0, 6'h39, 24'h5A_0500, 16'h1234, 1, 16'h0000},
    '{1, 2'h0, 6'h3D, 24'h5A_050C, 16'hBEEF, 1, 16'h0000},
    '{1, 2'h1, 6'h39, 24'h5A_0504, 16'hABCD, 1, 16'h0000},
    '{0, 2'h0, 6'h39, 24'h5A_0500, 16'h0000, 1, 16'h1234},
    '{0, 2'h0, 6'h39, 24'h5A_050C, 16'h0000, 1, 16'hBEEF},
    '{0, 2'h0, 6'h3D, 24'h5A_0504, 16'h0000, 1, 16'hAB00},
    '{1, 2'h0, 6'h39, 24'h5A_0020, 16'hFFFF, 1, 16'h0000},
    '{0, 2'h0, 6'h39, 24'h5A_0020, 16'h0000, 1, 16'h0A5C},
    '{0, 2'h0, 6'h39, 24'h5A_0000, 16'h0000, 1, 16'h255A},
    '{0, 2'h0, 6'h39, 24'h5A_040C, 16'h0000, 1, 16'h0000},
    '{0, 2'h0, 6'h39, 24'h5A_FFFC, 16'h0000, 1, 16'h0000},
    '{0, 2'h0, 6'h39, 24'h5A_FFFD, 16'h0000, 0, 16'h0000},
    '{1, 2'h0, 6'h39, 24'h5B_0500, 16'h5555, 0, 16'h0000},
    '{1, 2'h0, 6'h09, 24'h5A_0500, 16'h5555, 0, 16'h0000},
    '{0, 2'h0, 6'h39, 24'h5A_0500, 16'h0000, 1, 16'h1234}};
  always #20 ref_clk = ~ref_clk;
  vmsad_vme_slave #(.LED_CYCLES(20), .PULSE_CYCLES(5)) dut (.ref_clk, .arst_n, .vme_addr,
    .vme_am, .vme_as_n, .vme_ds_n, .vme_lword_n, .vme_write_n, .vme_data_in, .vme_data_out,
    .vme_data_oe, .vme_dtack_out(), .vme_dtack_oe, .base_switch, .ext_conn_present,
    .geo_addr_n, .geo_parity_n, .hw_status, .ctrl_out, .pulse_out, .access_led);
  vmsad_vme_master m (.ref_clk, .vme_addr, .vme_am, .vme_as_n, .vme_ds_n, .vme_lword_n,
    .vme_write_n, .vme_data_in, .vme_data_out, .vme_dtack_oe);
  task automatic cmp_d(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_b(input logic got, input logic exp);
    cmp_d({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic results;
    $display("%0d comparisons, %0d mismatches", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles.
  initial begin
    #(3000 * 40);
    num_errors++;
    results();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    cmp_b(access_led, 1'b0);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    foreach (rows[i]) begin
      m.hold = i % 3;
      m.cyc(rows[i].wr, rows[i].ds, rows[i].am, {8'h00, rows[i].a}, rows[i].d, q, ok);
      cmp_b(ok, rows[i].ack);
      if (rows[i].ack && !rows[i].wr) cmp_d(q, rows[i].exp);
    end
    cmp_d(ctrl_out[1][15:0], 16'hAB00);
    $display("table test done");
    m.hold = 0;
    m.cyc(1'b1, 2'h0, 6'h39, 32'h005A_040C, 16'h0005, q, ok);
    #1 cmp_d(pulse_out, 16'h0005);
    cmp_b(access_led, 1'b1);
    repeat (25) @(posedge ref_clk);
    cmp_d(pulse_out, 16'h0000);
    cmp_b(access_led, 1'b0);
    $display("pulse and lamp test done");
    ext_conn_present <= 1'b1;
    geo_addr_n <= 5'h1C;
    geo_parity_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    m.cyc(1'b0, 2'h0, 6'h39, 32'h0018_0000, 16'h0000, q, ok);
    cmp_b(ok, 1'b1);
    cmp_d(q, 16'h6518);
    m.cyc(1'b0, 2'h0, 6'h39, 32'h005A_0000, 16'h0000, q, ok);
    cmp_b(ok, 1'b0);
    geo_parity_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    m.cyc(1'b0, 2'h0, 6'h39, 32'h005A_0000, 16'h0000, q, ok);
    cmp_d(q, 16'h255A);
    ext_conn_present <= 1'b0;
    $display("geographic base test done");
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    cmp_d(ctrl_out[0][15:0], 16'h0000);
    cmp_b(access_led, 1'b0);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    m.cyc(1'b0, 2'h0, 6'h39, 32'h005A_0500, 16'h0000, q, ok);
    cmp_d(q, 16'h0000);
    $display("reset test done");
    results();
  end
endmodule // vmsad_vme_slave_tb
